/* adcseq_top.sv */
// serial sequencer: frame select and serial clock to result stream
`timescale 1ns/1ps
`include "adcseq_defs.svh"

module adcseq_top
    import adcseq_pkg::*;
#(
    parameter int FIFO_DEPTH = `ADCSEQ_FIFO_DEPTH
) (
    // system clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // serial link from the master, sampled on sys_clk
    input wire logic frame_sel_n,
    input wire logic sclk,
    // serial result line, tri-state as output plus enable
    output logic dout,
    output logic dout_oe,
    // successive_approximation_core results and hold strobe
    input wire logic [`ADCSEQ_RES_BITS-1:0] chan_a_differential_input,
    input wire logic [`ADCSEQ_RES_BITS-1:0] chan_b_differential_input,
    output logic sample_hold
);
    // refuse buffer depths the frame timing cannot serve
    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("adcseq_top: FIFO_DEPTH must be at least 2");
    end

    // the edge windows must each carry one full result word
    if ((`ADCSEQ_A_LAST - `ADCSEQ_A_FIRST + 6'h01) != 6'(`ADCSEQ_RES_BITS)) begin : g_bad_win_a
        $error("adcseq_top: channel A window does not match the result width");
    end
    if ((`ADCSEQ_B_LAST - `ADCSEQ_B_FIRST + 6'h01) != 6'(`ADCSEQ_RES_BITS)) begin : g_bad_win_b
        $error("adcseq_top: channel B window does not match the result width");
    end

    // channel B must end the conversion, so the wrap follows its last bit
    if (`ADCSEQ_B_LAST != `ADCSEQ_CONV_EDGES) begin : g_bad_frame
        $error("adcseq_top: channel B window must end on the last edge");
    end

    // the word is loaded between the hold edge and the first result edge
    if (`ADCSEQ_SAMPLE_EDGE >= `ADCSEQ_A_FIRST) begin : g_bad_hold
        $error("adcseq_top: hold edge must come before the first result edge");
    end

    // width of one stored pair
    localparam int PAIR_W = $bits(adcseq_pair_type);

    // registered state
    adcseq_state_type state_q, state_d; // frame state
    logic cs_prev_q, cs_prev_d; // frame select one cycle ago
    logic sclk_prev_q, sclk_prev_d; // serial clock one cycle ago
    logic [5:0] cnt_q, cnt_d; // falling edges seen in this conversion
    logic [PAIR_W-1:0] word_q, word_d; // shift register, A then B
    logic loaded_q, loaded_d; // word holds this conversion's results
    logic dout_q, dout_d; // serial data flop
    logic oe_q, oe_d; // output enable flop
    logic hold_q, hold_d; // sample strobe flop

    // combinational helpers
    logic frame_start; // frame select just fell
    logic fall_evt; // one falling serial clock edge counted
    logic [5:0] edge_n; // index of the edge being handled
    logic data_edge; // edge carries a result bit
    adcseq_pair_type pair_in; // sampled pair
    logic fifo_in_valid; // push request
    logic fifo_in_ready; // buffer has room
    logic fifo_out_valid; // buffer holds a pair
    logic fifo_out_ready; // serializer takes a pair
    logic [PAIR_W-1:0] fifo_out_data; // pair leaving the buffer

    // frame starts when select is seen low after being high
    assign frame_start = cs_prev_q && !frame_sel_n;

    // edge detector next values: remember both link levels every cycle
    always_comb begin
        cs_prev_d = frame_sel_n;
        sclk_prev_d = sclk;
    end

    // edge detector registers; select resets high so a held-low select starts a frame
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cs_prev_q <= 1'b1;
            sclk_prev_q <= 1'b0;
        end else begin
            cs_prev_q <= cs_prev_d;
            sclk_prev_q <= sclk_prev_d;
        end
    end

    // edge detection; a frame select fall with serial clock low is edge one
    always_comb begin
        fall_evt = 1'b0;
        edge_n = cnt_q + 6'h01;
        // edges count only while the link is selected
        if (!frame_sel_n) begin
            if (frame_start) begin
                fall_evt = !sclk;
                edge_n = 6'h01;
            end else if (state_q == ADCSEQ_ACTIVE) begin
                fall_evt = sclk_prev_q && !sclk;
            end
        end
    end

    // result bits sit on edges 5-16 and 21-32, zeros elsewhere
    assign data_edge = ((edge_n >= `ADCSEQ_A_FIRST) && (edge_n <= `ADCSEQ_A_LAST)) ||
                       ((edge_n >= `ADCSEQ_B_FIRST) && (edge_n <= `ADCSEQ_B_LAST));

    // both channels are captured together on the fourth edge
    assign pair_in.chan_a = chan_a_differential_input;
    assign pair_in.chan_b = chan_b_differential_input;
    assign fifo_in_valid = fall_evt && (edge_n == `ADCSEQ_SAMPLE_EDGE);

    // serializer drains only once the hold has happened and the slot is free
    // the pop lands the cycle after edge four, so edge five must come two cycles later
    assign fifo_out_ready = (state_q == ADCSEQ_ACTIVE) && !frame_sel_n && !loaded_q &&
                            (cnt_q >= `ADCSEQ_SAMPLE_EDGE);

    // buffer between the converter and the serializer
    adcseq_fifo #(
        .WIDTH(PAIR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(sys_clk),
        .reset_n(reset_n),
        .flush(frame_sel_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(pair_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // one conversion, counted in falling serial clock edges:
    //   1-4   acquisition, line low; the pair is pushed on edge four
    //   5-16  channel A, most significant bit first
    //   17-20 four zero bits between the two results
    //   21-32 channel B, most significant bit first
    //   after 32 the count wraps and the next conversion follows at once
    // sequencer next values
    always_comb begin
        // hold everything by default; the hold strobe is a one-cycle pulse
        state_d = state_q;
        cnt_d = cnt_q;
        word_d = word_q;
        loaded_d = loaded_q;
        dout_d = dout_q;
        oe_d = oe_q;
        hold_d = 1'b0;
        // select high wins over every other event
        if (frame_sel_n) begin
            // frame ended or aborted: float the line, drop the conversion
            state_d = ADCSEQ_IDLE;
            oe_d = 1'b0;
            dout_d = 1'b0;
            cnt_d = `ADCSEQ_CNT_RESET;
            loaded_d = 1'b0;
        end else begin
            if (frame_start) begin
                // new frame: drive the line, acquisition begins
                state_d = ADCSEQ_ACTIVE;
                oe_d = 1'b1;
                dout_d = 1'b0;
                cnt_d = `ADCSEQ_CNT_RESET;
                loaded_d = 1'b0;
            end
            if (fall_evt) begin
                // wrap after the last edge so the next conversion follows
                if (edge_n == `ADCSEQ_CONV_EDGES) begin
                    cnt_d = `ADCSEQ_CNT_RESET;
                    loaded_d = 1'b0;
                end else begin
                    cnt_d = edge_n;
                end
                // hold strobe to the converter core
                if (edge_n == `ADCSEQ_SAMPLE_EDGE) begin
                    hold_d = fifo_in_ready;
                end
                // shift MSB first, zeros outside the result windows
                if (data_edge && loaded_q) begin
                    dout_d = word_q[PAIR_W-1];
                    word_d = {word_q[PAIR_W-2:0], 1'b0};
                end else begin
                    dout_d = 1'b0;
                end
            end
            // load this conversion's pair before the fifth edge
            if (fifo_out_valid && fifo_out_ready) begin
                word_d = fifo_out_data;
                loaded_d = 1'b1;
            end
        end
    end

    // sequencer registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            // reset: line floated, counter cleared, nothing loaded
            state_q <= ADCSEQ_IDLE;
            cnt_q <= `ADCSEQ_CNT_RESET;
            word_q <= '0;
            loaded_q <= 1'b0;
            dout_q <= 1'b0;
            oe_q <= 1'b0;
            hold_q <= 1'b0;
        end else begin
            // normal operation: take the next values
            state_q <= state_d;
            cnt_q <= cnt_d;
            word_q <= word_d;
            loaded_q <= loaded_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
            hold_q <= hold_d;
        end
    end

    // outputs straight from flops
    assign dout = dout_q;
    assign dout_oe = oe_q;
    assign sample_hold = hold_q;

endmodule // adcseq_top

/* adcseq_defs.svh */
// constants for the dual converter serial result sequencer
`ifndef ADCSEQ_DEFS_SVH
`define ADCSEQ_DEFS_SVH

// result word width
`define ADCSEQ_RES_BITS 12
// falling edges per conversion
`define ADCSEQ_CONV_EDGES 6'h20
// falling edge on which both inputs are held
`define ADCSEQ_SAMPLE_EDGE 6'h04
// channel A result window
`define ADCSEQ_A_FIRST 6'h05
`define ADCSEQ_A_LAST 6'h10
// channel B result window
`define ADCSEQ_B_FIRST 6'h15
`define ADCSEQ_B_LAST 6'h20
// result buffer depth
`define ADCSEQ_FIFO_DEPTH 8
// reset value of the edge counter
`define ADCSEQ_CNT_RESET 6'h00

`endif

/* adcseq_pkg.sv */
// types used by the sequencer; its result buffer takes the pair as plain bits
`include "adcseq_defs.svh"

package adcseq_pkg;

    // one simultaneous sample: channel A and channel B, two's complement
    typedef struct packed {
        logic [`ADCSEQ_RES_BITS-1:0] chan_a;
        logic [`ADCSEQ_RES_BITS-1:0] chan_b;
    } adcseq_pair_type;

    // frame state of the serial sequencer
    typedef enum logic [0:0] {
        ADCSEQ_IDLE = 1'b0,
        ADCSEQ_ACTIVE = 1'b1
    } adcseq_state_type;

endpackage

/* adcseq_fifo.sv */
// result buffer with valid and ready on both sides
`timescale 1ns/1ps

module adcseq_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic flush,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // refuse shapes the pointer logic cannot serve
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_shape
        $error("adcseq_fifo: DEPTH must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH]; // storage
    logic [AW-1:0] wr_ptr_q, wr_ptr_d; // write pointer
    logic [AW-1:0] rd_ptr_q, rd_ptr_d; // read pointer
    logic [AW:0] cnt_q, cnt_d; // fill level
    logic push, pop; // handshakes

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_ptr_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer and level next values; flush empties the buffer
    always_comb begin
        wr_ptr_d = wr_ptr_q + AW'(push);
        rd_ptr_d = rd_ptr_q + AW'(pop);
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        if (flush) begin
            wr_ptr_d = '0;
            rd_ptr_d = '0;
            cnt_d = '0;
        end
    end

    // pointer and level registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            cnt_q <= cnt_d;
        end
    end

    // storage write, no reset needed
    always_ff @(posedge clk) begin
        if (push && !flush) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

endmodule // adcseq_fifo

/* adcseq_asserts.sv */
// checker for the serial result sequencer
`timescale 1ns/1ps

module adcseq_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // serial link
    input wire logic frame_sel_n,
    input wire logic sclk,
    input wire logic dout,
    input wire logic dout_oe,
    // converter side
    input wire logic [11:0] chan_a_differential_input,
    input wire logic [11:0] chan_b_differential_input,
    input wire logic sample_hold
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // previous levels, falling edge count and held words
    logic fs_q, sc_q, fall;
    logic [5:0] cnt_q, cnt_d;
    logic [11:0] a_q, b_q;
    // a select fall with the clock low counts as edge one
    assign fall = !frame_sel_n && !sclk && (sc_q || fs_q);
    // edge count wraps after thirty-two
    always_comb begin
        cnt_d = cnt_q;
        if (frame_sel_n) cnt_d = 6'h00;
        else if (fall) cnt_d = (cnt_q == 6'h20) ? 6'h01 : cnt_q + 6'h01;
    end
    // tracker registers, words taken on edge four
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fs_q <= 1'b1;
            sc_q <= 1'b1;
            cnt_q <= 6'h00;
            a_q <= 12'h000;
            b_q <= 12'h000;
        end else begin
            fs_q <= frame_sel_n;
            sc_q <= sclk;
            cnt_q <= cnt_d;
            if (fall && cnt_q == 6'h03) a_q <= chan_a_differential_input;
            if (fall && cnt_q == 6'h03) b_q <= chan_b_differential_input;
        end
    end
    oe_on_a: assert property ($fell(frame_sel_n) |=> dout_oe)
        else $error("line not driven after select fall");
    oe_off_a: assert property (frame_sel_n |=> !dout_oe)
        else $error("line driven with select high");
    idle_low_a: assert property (frame_sel_n [*2] |=> !dout)
        else $error("line not low outside frame");
    hold_edge_a: assert property (fall && cnt_q == 6'h03 |=> sample_hold)
        else $error("no hold on edge four");
    hold_late_a: assert property (sample_hold |-> cnt_q == 6'h04)
        else $error("hold outside edge four");
    a_bits_a: assert property (fall && cnt_q inside {[4:15]} |=> dout == a_q[16-cnt_q])
        else $error("wrong channel A bit");
    b_bits_a: assert property (fall && cnt_q inside {[20:31]} |=> dout == b_q[32-cnt_q])
        else $error("wrong channel B bit");
    pad_zero_a: assert property (fall && cnt_q inside {[0:3], [16:19], 32} |=> !dout)
        else $error("padding bit not zero");
    on_fall_a: assert property (dout_oe && $changed(dout) |-> $past(fall))
        else $error("line changed off a falling edge");
    cover property (sample_hold);
    cover property (fall && cnt_q == 6'h20);
    cover property ($rose(frame_sel_n) && cnt_q inside {[1:15]});
endmodule // adcseq_chk

bind adcseq_top adcseq_chk u_adcseq_chk (.*);

/* adcseq_master.sv */
// serial master model: frames select, clocks the line, collects bits
`timescale 1ns/1ps

module adcseq_master (
    // control from the bench
    input wire logic sys_clk,
    input wire logic run,
    input wire logic [3:0] half,
    // serial link
    output logic frame_sel_n,
    output logic sclk,
    input wire logic dout,
    input wire logic dout_oe,
    // collected bits
    output logic [31:0] rx,
    output logic [7:0] nbits
);
    logic [3:0] ph;
    logic line;
    // a released line shows the inverse of the last bit, never a stale copy
    assign line = dout_oe ? dout : ~rx[0];
    initial begin
        frame_sel_n = 1'b1;
        sclk = 1'b1;
        rx = 32'h0000_0000;
        nbits = 8'h00;
        ph = 4'h0;
    end
    // clock stands still high outside frames
    always @(negedge sys_clk) begin
        if (!run) begin
            sclk <= 1'b1;
            nbits <= 8'h00;
            ph <= 4'h0;
        end else if (ph == half - 4'h1) begin
            ph <= 4'h0;
            sclk <= ~sclk;
            if (!sclk) begin
                rx <= {rx[30:0], line};
                nbits <= nbits + 8'h01;
            end
        end else begin
            ph <= ph + 4'h1;
        end
        frame_sel_n <= !run;
    end
endmodule // adcseq_master

/* adcseq_top_tb.sv */
// self-checking bench for the serial result sequencer
`timescale 1ns/1ps

module adcseq_top_tb;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic run = 1'b0;
    logic [3:0] half = 4'h2;
    logic [11:0] ch_a = 12'h000;
    logic [11:0] ch_b = 12'h000;
    logic frame_sel_n, sclk, dout, dout_oe, sample_hold;
    logic [31:0] rx;
    logic [7:0] nbits;
    int failures = 0;
    int n_tests = 0;
    int hold_count = 0;
    initial forever #50 sys_clk = ~sys_clk;
    // count hold strobes away from the edge that launches them
    always @(negedge sys_clk) begin
        if (sample_hold === 1'b1) hold_count <= hold_count + 1;
    end
    adcseq_top u_adcseq_top (.sys_clk(sys_clk), .reset_n(reset_n), .frame_sel_n(frame_sel_n),
        .sclk(sclk), .dout(dout), .dout_oe(dout_oe), .chan_a_differential_input(ch_a),
        .chan_b_differential_input(ch_b), .sample_hold(sample_hold));
    adcseq_master u_adcseq_master (.sys_clk(sys_clk), .run(run), .half(half),
        .frame_sel_n(frame_sel_n), .sclk(sclk), .dout(dout), .dout_oe(dout_oe),
        .rx(rx), .nbits(nbits));
    // compare and count
    task check(logic [11:0] got, logic [11:0] exp, string msg);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task give_verdict();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // bounded wait for the master's bit count
    task wait_bits(int n);
        for (int i = 0; i < 3000 && nbits < n; i++) @(negedge sys_clk);
        if (nbits < n) begin
            failures++;
            $display("ERROR %0t wait ran out", $time);
            give_verdict();
        end
    endtask
    // one frame of one conversion, then release
    task frame(logic [11:0] a, logic [11:0] b, logic [3:0] h);
        ch_a = a;
        ch_b = b;
        half = h;
        run <= 1'b1;
        wait_bits(32);
        run <= 1'b0;
        check(rx[27:16], a, "chan a");
        check({rx[31:28], rx[15:12], 4'h0}, 12'h000, "padding");
        check(rx[11:0], b, "chan b");
        repeat (3) @(negedge sys_clk);
        check({11'h000, dout_oe}, 12'h000, "release");
        $display("frame %h %h done", a, b);
    endtask
    // two conversions in one frame with new inputs for the second
    task back_to_back();
        int hold_start;
        hold_start = hold_count;
        ch_a = 12'h123;
        ch_b = 12'hedc;
        half = 4'h3;
        run <= 1'b1;
        wait_bits(32);
        check(rx[27:16], 12'h123, "first a");
        check(rx[11:0], 12'hedc, "first b");
        ch_a = 12'h456;
        ch_b = 12'h789;
        wait_bits(64);
        run <= 1'b0;
        check(rx[27:16], 12'h456, "second a");
        check(rx[11:0], 12'h789, "second b");
        check(12'(hold_count - hold_start), 12'h002, "holds");
        repeat (3) @(negedge sys_clk);
        $display("back to back done");
    endtask
    // select raised in the middle of channel A, then a clean frame
    task abort_mid();
        half = 4'h2;
        run <= 1'b1;
        wait_bits(10);
        run <= 1'b0;
        repeat (3) @(negedge sys_clk);
        check({11'h000, dout_oe}, 12'h000, "abort");
        frame(12'h00f, 12'hf00, 4'h2);
        $display("abort done");
    endtask
    initial begin
        repeat (6) @(negedge sys_clk);
        reset_n = 1'b1;
        @(negedge sys_clk);
        frame(12'h7ff, 12'h800, 4'h2);
        frame(12'h800, 12'h7ff, 4'h5);
        back_to_back();
        abort_mid();
        give_verdict();
    end
endmodule // adcseq_top_tb
